// ===== hw/eeprom_pkg.sv
/*
  Constants, commands and types for the serial memory slave front end.
  Assumes a 20 MHz system clock; all serial pins are asynchronous to it.
*/
package eeprom_pkg;

  // ==========================================================
  // timing
  localparam int CLK_FREQ_HZ   = 20_000_000;
  localparam int WRITE_TIME_US = 5000;
  // longest time: rounds down to whole cycles
  localparam int WRITE_CYCLES  = WRITE_TIME_US * (CLK_FREQ_HZ / 1_000_000);

  // ==========================================================
  // memory map
  localparam int MEM_BYTES   = 65536;
  localparam int PAGE_BYTES  = 128;
  localparam int SEC_BYTES   = 128;
  localparam int UID_BITS    = 128;
  localparam int UID_SEL_BIT = 9;
  localparam int SEC_HI_BIT  = 10;
  localparam int SEC_LO_BIT  = 9;
  localparam int PIN_COUNT   = 5;

  // ==========================================================
  // instruction codes
  localparam logic [7:0] CMD_WRSR      = 8'h01;
  localparam logic [7:0] CMD_WRITE     = 8'h02;
  localparam logic [7:0] CMD_READ      = 8'h03;
  localparam logic [7:0] CMD_WRDI      = 8'h04;
  localparam logic [7:0] CMD_RDSR      = 8'h05;
  localparam logic [7:0] CMD_WREN      = 8'h06;
  localparam logic [7:0] CMD_SEC_WRITE = 8'h82;
  localparam logic [7:0] CMD_SEC_READ  = 8'h83;

  // ==========================================================
  // status byte layout and reset values
  localparam int ST_IN_PROGRESS = 0;
  localparam int ST_PERMIT      = 1;
  localparam int ST_BP_LO       = 2;
  localparam int ST_BP_HI       = 3;
  localparam int ST_LOCK        = 7;
  localparam logic [1:0]           BP_RESET   = 2'h0;
  localparam logic                 LOCK_RESET = 1'b0;
  // select resets low: a pin held low since power-up never shows a fall
  localparam logic [PIN_COUNT-1:0] PIN_RESET  = 5'h0F;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    FR_IDLE = 3'b000,
    FR_CMD  = 3'b001,
    FR_ADDR = 3'b011,
    FR_DATA = 3'b010,
    FR_SKIP = 3'b110
  } frame_t;

  typedef enum logic [1:0] {
    WK_MAIN   = 2'b00,
    WK_SEC    = 2'b01,
    WK_STATUS = 2'b11
  } wkind_t;

endpackage

// ===== hw/pin_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous pins.
  Assumes a synchronous active-high reset in the destination domain.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int             W     = 5,
  parameter logic [W-1:0]   RESET = '1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // pin group
  pin_sync_if.sync_side     pins
);
  logic [W-1:0] meta;

  // first stage is read by the second stage only
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta      <= RESET;
      pins.sync <= RESET;
    end else begin
      meta      <= pins.raw;
      pins.sync <= meta;
    end
  end
endmodule

// ===== hw/pin_sync_if.sv
/*
  Raw and synchronised serial pin group.
  Assumes the owner drives raw and the synchroniser drives sync.
*/
`timescale 1ns/100ps
interface pin_sync_if #(parameter int W = 5);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport sync_side (input raw, output sync);
  modport user      (output raw, input sync);
endinterface

// ===== hw/spi_eeprom_slave.sv
/*
  Serial peripheral slave front end of a 64 KiB byte memory with security
  sector and unique identifier, oversampling the serial pins.
  Assumes the serial clock runs well below a quarter of I_CLK.
*/
// Contract
// RULE_01: input bits sampled on serial clock rise
// RULE_02: output bits change on serial clock fall
// RULE_03: deselected device keeps output floating
// RULE_04: work only while select is low
// RULE_05: ignore everything until first select fall
// RULE_06: pause floats output, ignores clock and input
// RULE_07: pause release resumes where it stopped
// RULE_08: lock bit with guard low refuses status writes
// RULE_09: clock modes zero and three both work
// RULE_10: main array 512 pages of 128 bytes
// RULE_11: single byte and page writes supported
// RULE_12: security sector in 8x family, A10:A9 zero
// RULE_13: read-only 128-bit identifier via 83h
// RULE_14: self-timed write, at most 5 ms
// RULE_15: command first, all fields MSB first
// RULE_16: pause changes wait for clock low
// RULE_17: busy: only status read accepted
// RULE_18: write permit needed, cleared after writes
`timescale 1ns/100ps
module spi_eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int                  WRITE_CYCLES_P = WRITE_CYCLES,
  // arbitrary identifier value
  parameter logic [UID_BITS-1:0] UNIQUE_ID      = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
  // clock and reset
  input  wire logic I_CLK,
  input  wire logic I_RST,
  // serial link pins
  input  wire logic I_CS_N,
  input  wire logic I_SCLK,
  input  wire logic I_SERIAL_IN,
  input  wire logic I_HOLD_N,
  input  wire logic I_WP_N,
  // serial output pin
  output logic      O_SO,
  output logic      O_SO_OE_N
);
  localparam int WCW = $clog2(WRITE_CYCLES_P + 1);

  // ==========================================================
  // pin synchronisers
  pin_sync_if #(.W(PIN_COUNT)) pins ();
  logic cs_n, sclk, sin, hold_n, wp_n;

  assign pins.raw = {I_CS_N, I_SCLK, I_SERIAL_IN, I_HOLD_N, I_WP_N};
  assign {cs_n, sclk, sin, hold_n, wp_n} = pins.sync;

  pin_sync #(.W(PIN_COUNT), .RESET(PIN_RESET)) u_sync (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .pins  (pins.sync_side)
  );

  // ==========================================================
  // edge and pause detection
  logic   cs_prev, sclk_prev, hold_on;
  frame_t state;
  logic   frame_start, frame_end, active, rise, fall;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cs_prev   <= 1'b0;  // a high select must be seen before any frame [RULE_05]
      sclk_prev <= 1'b0;
    end else begin
      cs_prev   <= cs_n;
      sclk_prev <= sclk;
    end
  end

  // pause toggles only while the clock is low [RULE_16] [RULE_06]
  always_ff @(posedge I_CLK) begin
    if (I_RST || cs_n) begin
      hold_on <= 1'b0;
    end else if (!sclk) begin
      hold_on <= ~hold_n;
    end
  end

  assign frame_start = cs_prev & ~cs_n;  // [RULE_15]
  assign frame_end   = ~cs_prev & cs_n;
  // both edges found from samples, idle level irrelevant [RULE_09] [RULE_04]
  assign active = ~cs_n & ~hold_on & (state != FR_IDLE);  // frame state kept [RULE_07]
  assign rise   = active & sclk & ~sclk_prev;   // [RULE_01]
  assign fall   = active & ~sclk & sclk_prev;   // [RULE_02]

  // ==========================================================
  // frame decoder
  logic [7:0]  cmd;
  logic [6:0]  shreg;
  logic [2:0]  bitcnt;
  logic [15:0] addr;
  logic        abytes, got_data, load_pend, busy;
  logic [7:0]  byte_in;
  logic        byte_done, cmd_done, is_read, is_write;
  frame_t      next_cmd_state;

  assign byte_in   = {shreg, sin};  // MSB arrives first [RULE_15]
  assign byte_done = rise && (bitcnt == 3'd7);
  assign cmd_done  = byte_done && (state == FR_CMD);
  assign is_read   = (cmd == CMD_READ) || (cmd == CMD_SEC_READ) || (cmd == CMD_RDSR);
  assign is_write  = (cmd == CMD_WRITE) || (cmd == CMD_SEC_WRITE) || (cmd == CMD_WRSR);

  always_comb begin
    if (busy && byte_in != CMD_RDSR) begin
      next_cmd_state = FR_SKIP;  // [RULE_17]
    end else begin
      case (byte_in)
        CMD_READ, CMD_WRITE, CMD_SEC_READ, CMD_SEC_WRITE: next_cmd_state = FR_ADDR;
        CMD_RDSR, CMD_WRSR:                               next_cmd_state = FR_DATA;
        default:                                          next_cmd_state = FR_SKIP;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST || cs_n) begin
      state     <= FR_IDLE;
      bitcnt    <= 3'd0;
      load_pend <= 1'b0;
      if (I_RST) begin
        cmd      <= 8'h00;
        shreg    <= 7'h00;
        addr     <= 16'h0000;
        abytes   <= 1'b0;
        got_data <= 1'b0;
      end
    end else if (frame_start) begin
      state    <= FR_CMD;
      bitcnt   <= 3'd0;
      addr     <= 16'h0000;
      abytes   <= 1'b0;
      got_data <= 1'b0;
    end else begin
      load_pend <= 1'b0;
      if (rise) begin
        shreg  <= byte_in[6:0];
        bitcnt <= bitcnt + 3'd1;
        if (bitcnt == 3'd7) begin
          case (state)
            FR_CMD: begin
              cmd       <= byte_in;
              state     <= next_cmd_state;
              load_pend <= (next_cmd_state == FR_DATA);
            end
            FR_ADDR: begin
              addr   <= {addr[7:0], byte_in};
              abytes <= 1'b1;
              if (abytes) begin
                state     <= FR_DATA;
                load_pend <= is_read;
              end
            end
            FR_DATA: begin
              got_data <= 1'b1;
              if (is_write) begin
                addr[6:0] <= addr[6:0] + 7'd1;  // wraps inside the page [RULE_11]
              end else begin
                addr      <= addr + 16'd1;
                load_pend <= 1'b1;
              end
            end
            default: state <= state;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // storage and write buffer
  logic [7:0]            mem [MEM_BYTES];   // [RULE_10]
  logic [7:0]            sec [SEC_BYTES];   // [RULE_12]
  logic [7:0]            pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask;
  logic                  write_permit_latch, lock;
  logic [1:0]            bp;
  logic [7:0]            status, rd_byte;

  function automatic logic prot(input logic [1:0] lvl, input logic [1:0] top);
    case (lvl)
      2'd1:    prot = (top == 2'd3);
      2'd2:    prot = top[1];
      2'd3:    prot = 1'b1;
      default: prot = 1'b0;
    endcase
  endfunction

  assign status = {lock, 3'b000, bp, write_permit_latch, busy};

  always_comb begin
    case (cmd)
      CMD_RDSR: rd_byte = status;
      CMD_READ: rd_byte = mem[addr];
      CMD_SEC_READ: begin
        if (addr[UID_SEL_BIT]) begin
          rd_byte = UNIQUE_ID[UID_BITS-1-8*addr[3:0] -: 8];  // [RULE_13]
        end else begin
          rd_byte = sec[addr[6:0]];  // [RULE_12]
        end
      end
      default:  rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (byte_done && state == FR_DATA && is_write) begin
      pbuf[addr[6:0]] <= byte_in;
    end
  end

  always_ff @(posedge I_CLK) begin
    // a status poll during the write must not wipe the pending page
    if (I_RST || (frame_start && !busy)) begin
      mask <= '0;
    end else if (byte_done && state == FR_DATA && is_write) begin
      mask[addr[6:0]] <= 1'b1;
    end
  end

  // ==========================================================
  // self-timed write cycle
  logic [WCW-1:0] wcnt;
  logic [8:0]     page;
  wkind_t         wkind;
  logic           commit, cmd_ok;

  always_comb begin
    case (cmd)
      CMD_WRITE:     cmd_ok = ~prot(bp, addr[15:14]);
      CMD_SEC_WRITE: cmd_ok = ~addr[SEC_HI_BIT] & ~addr[SEC_LO_BIT];  // [RULE_12]
      CMD_WRSR:      cmd_ok = ~(lock & ~wp_n);  // [RULE_08]
      default:       cmd_ok = 1'b0;
    endcase
  end

  // whole bytes only, and only with write permit [RULE_18]
  assign commit = frame_end && state == FR_DATA && bitcnt == 3'd0 && got_data
                  && write_permit_latch && cmd_ok;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      busy  <= 1'b0;
      wcnt  <= '0;
      write_permit_latch <= 1'b0;  // [RULE_18]
      lock  <= LOCK_RESET;
      bp    <= BP_RESET;
      wkind <= WK_MAIN;
      page  <= 9'h000;
    end else if (busy) begin
      wcnt <= wcnt + WCW'(1);  // [RULE_14]
      if (wcnt == WCW'(WRITE_CYCLES_P - 1)) begin
        busy <= 1'b0;
        write_permit_latch <= 1'b0;  // [RULE_18]
        if (wkind == WK_STATUS) begin
          lock <= pbuf[0][ST_LOCK];
          bp   <= pbuf[0][ST_BP_HI:ST_BP_LO];
        end
      end
    end else if (commit) begin
      busy  <= 1'b1;
      wcnt  <= '0;
      page  <= addr[15:7];
      wkind <= (cmd == CMD_WRSR) ? WK_STATUS : (cmd == CMD_SEC_WRITE) ? WK_SEC : WK_MAIN;
    end else if (cmd_done && byte_in == CMD_WREN) begin
      write_permit_latch <= 1'b1;
    end else if (cmd_done && byte_in == CMD_WRDI) begin
      write_permit_latch <= 1'b0;
    end
  end

  // page copy runs in the first cycles of the write; needs WRITE_CYCLES_P >= 128
  always_ff @(posedge I_CLK) begin
    if (busy && wcnt < WCW'(PAGE_BYTES) && mask[wcnt[6:0]]) begin
      if (wkind == WK_MAIN) begin
        mem[{page, wcnt[6:0]}] <= pbuf[wcnt[6:0]];  // [RULE_11]
      end else if (wkind == WK_SEC) begin
        sec[wcnt[6:0]] <= pbuf[wcnt[6:0]];
      end
    end
  end

  // ==========================================================
  // serial output
  logic [7:0] outreg;

  always_ff @(posedge I_CLK) begin
    if (I_RST || cs_n) begin
      outreg    <= 8'h00;
      O_SO      <= 1'b0;
      O_SO_OE_N <= 1'b1;  // [RULE_03]
    end else begin
      O_SO_OE_N <= ~(~hold_on & state == FR_DATA & is_read);  // [RULE_06]
      if (load_pend) begin
        outreg <= rd_byte;
      end else if (fall && state == FR_DATA && is_read) begin
        O_SO   <= outreg[7];  // [RULE_02]
        outreg <= {outreg[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  sequence seq_held;
    hold_on && !cs_n;
  endsequence

  sequence seq_wrsr_locked;
    frame_end && state == FR_DATA && cmd == CMD_WRSR && lock && !wp_n;
  endsequence

  chk_desel_float: assert property (cs_n |=> O_SO_OE_N)  // [RULE_03]
    else $error("output driven while deselected");
  chk_hold_float: assert property (hold_on |=> O_SO_OE_N)  // [RULE_06]
    else $error("output driven during pause");
  chk_hold_freeze: assert property (  // [RULE_07]
    seq_held ##1 seq_held |-> $stable(bitcnt) && $stable(state))
    else $error("frame moved during pause");
  chk_out_on_fall: assert property ($changed(O_SO) |-> $past(fall) || $past(cs_n))  // [RULE_02]
    else $error("output changed off a falling edge");
  chk_sample_rise: assert property ($changed(shreg) |-> $past(rise))  // [RULE_01]
    else $error("input shifted off a rising edge");
  chk_no_early: assert property (  // [RULE_05]
    state == FR_IDLE && !cs_n && !$past(cs_n) |=> state == FR_IDLE)
    else $error("frame began without select fall");
  chk_hw_protect: assert property (seq_wrsr_locked |=> !busy)  // [RULE_08]
    else $error("status write accepted while protected");
  chk_busy_length: assert property (  // [RULE_14]
    $fell(busy) |-> $past(wcnt) == WCW'(WRITE_CYCLES_P - 1))
    else $error("write cycle length wrong");
  chk_permit_cleared: assert property ($fell(busy) |-> !write_permit_latch)  // [RULE_18]
    else $error("write permit left set after write");
  chk_busy_skip: assert property (  // [RULE_17]
    busy && cmd_done && byte_in != CMD_RDSR |=> state inside {FR_SKIP, FR_IDLE})
    else $error("instruction accepted while busy");

endmodule

// ===== sim/spi_master_model.sv
/*
  Behavioural serial bus master that drives select, clock, data and pause.
  Assumes the slave samples these pins with a 50 ns clock given on i_clk.
*/
`timescale 1ns/100ps
module spi_master_model (
  // system clock, used only to pace the serial pins
  input  wire logic i_clk,
  // serial link, master side
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_serial_in,
  output logic      o_hold_n,
  input  wire logic i_so,
  input  wire logic i_so_oe_n
);
  logic       mode3;
  logic       so_last;
  logic [7:0] rx;
  logic       so_w;
  event       got;

  initial begin
    mode3       = 1'b0;
    o_cs_n      = 1'b0;
    o_sclk      = 1'b0;
    o_serial_in = 1'b0;
    o_hold_n    = 1'b1;
  end

  // a floating output reads back as the inverse of its last driven level
  always @(i_so or i_so_oe_n) begin
    if (!i_so_oe_n) begin
      so_last = i_so;
    end
  end
  assign so_w = i_so_oe_n ? ~so_last : i_so;

  // ==========================================================
  // link timing: each clock level lasts 4 system clocks (400 ns period)
  task automatic half();
    repeat (4) @(posedge i_clk);
    #5;
  endtask

  task automatic start();
    o_sclk = mode3;         // idle level picks the clock mode
    half();
    o_cs_n = 1'b0;          // every frame opens with a select fall
    half();
  endtask

  task automatic stop();
    if (!mode3) begin
      o_sclk = 1'b0;
      half();
    end
    o_cs_n      = 1'b1;
    o_serial_in = ~o_serial_in;
    half();
    half();
  endtask

  task automatic xfer(input logic [7:0] b, input logic keep);
    for (int i = 7; i >= 0; i--) begin
      o_sclk      = 1'b0;
      o_serial_in = b[i];   // most significant bit first
      half();
      o_sclk      = 1'b1;   // data stable across the rise, select low
      rx[i]       = so_w;
      half();
    end
    if (keep) begin
      ->got;
    end
  endtask

  // pause requested while the clock is high, so it waits for the next fall
  task automatic hold_gap(input int n, output logic oe_seen);
    oe_seen  = 1'b1;
    o_hold_n = 1'b0;
    half();
    o_sclk = 1'b0;
    half();
    half();
    repeat (n) begin
      oe_seen     = oe_seen & i_so_oe_n;
      o_sclk      = 1'b1;
      o_serial_in = 1'($urandom);
      half();
      o_sclk = 1'b0;
      half();
    end
    oe_seen  = oe_seen & i_so_oe_n;
    o_hold_n = 1'b1;
    half();
  endtask
endmodule

// ===== sim/tb_top.sv
/*
  Self-checking bench for the serial memory slave front end.
  Assumes the master model in spi_master_model.sv and the eeprom package.
*/
`timescale 1ns/100ps
module tb_top;
  import eeprom_pkg::*;
  localparam int WC = 1000;
  // arbitrary identifier value
  localparam logic [UID_BITS-1:0] UID = 128'hA5C3_1E07_6B2D_94F8_0C71_E5A2_3D96_B48F;

  logic              clk;
  logic              rst;
  logic              wp_n;
  logic              cs_n;
  logic              sclk;
  logic              sdi;
  logic              hold_n;
  logic              so;
  logic              so_oe_n;
  int                fails;
  int                n_compared;
  int unsigned       seed;
  logic [7:0]        exp_q[$];
  logic [7:0]        msk_q[$];
  string             name_q[$];
  logic [7:0]        msk_w;
  logic [7:0]        wq[$];
  logic [7:0]        eq[$];
  logic [7:0]        d[4];
  logic [8:0]        pg;
  logic [15:0]       sa;

  spi_eeprom_slave #(
    .WRITE_CYCLES_P (WC),
    .UNIQUE_ID      (UID)
  ) uut (
    .I_CLK       (clk),
    .I_RST       (rst),
    .I_CS_N      (cs_n),
    .I_SCLK      (sclk),
    .I_SERIAL_IN (sdi),
    .I_HOLD_N    (hold_n),
    .I_WP_N      (wp_n),
    .O_SO        (so),
    .O_SO_OE_N   (so_oe_n)
  );

  spi_master_model m_mst (
    .i_clk       (clk),
    .o_cs_n      (cs_n),
    .o_sclk      (sclk),
    .o_serial_in (sdi),
    .o_hold_n    (hold_n),
    .i_so        (so),
    .i_so_oe_n   (so_oe_n)
  );

  always #25 clk = ~clk;

  // ==========================================================
  // checking
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // every byte the master keeps is matched against the oldest note
  initial begin
    forever begin
      @(m_mst.got);
      msk_w = msk_q.pop_front();
      chk(name_q.pop_front(), exp_q.pop_front() & msk_w, m_mst.rx & msk_w);
    end
  end

  initial begin
    #3_000_000;
    fails++;
    final_report();
  end

  // ==========================================================
  // frames
  task automatic expect_b(input string nm, input logic [7:0] e, input logic [7:0] m);
    name_q.push_back(nm);
    exp_q.push_back(e);
    msk_q.push_back(m);
    m_mst.xfer(8'h00, 1'b1);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [15:0] a);
    m_mst.start();
    m_mst.xfer(op, 1'b0);
    m_mst.xfer(a[15:8], 1'b0);
    m_mst.xfer(a[7:0], 1'b0);
  endtask

  task automatic one(input logic [7:0] op);
    m_mst.start();
    m_mst.xfer(op, 1'b0);
    m_mst.stop();
  endtask

  task automatic status(input logic [7:0] e, input logic [7:0] m);
    m_mst.start();
    m_mst.xfer(CMD_RDSR, 1'b0);
    expect_b("status", e, m);
    m_mst.stop();
  endtask

  task automatic wr(input logic [7:0] op, input logic [15:0] a, input logic en);
    if (en) one(CMD_WREN);  // permit first
    cmd(op, a);
    foreach (wq[i]) m_mst.xfer(wq[i], 1'b0);
    m_mst.stop();
  endtask

  task automatic wsr(input logic [7:0] v);
    one(CMD_WREN);
    m_mst.start();
    m_mst.xfer(CMD_WRSR, 1'b0);
    m_mst.xfer(v, 1'b0);
    m_mst.stop();
  endtask

  task automatic rd(input string nm, input logic [7:0] op, input logic [15:0] a, input int hi);
    logic oe_hi;
    cmd(op, a);
    foreach (eq[i]) begin
      if (i == hi) begin
        m_mst.hold_gap(3, oe_hi);
        chk("output enable in pause", 8'h01, {7'h00, oe_hi});
      end
      expect_b(nm, eq[i], 8'hFF);
    end
    m_mst.stop();
    chk("output enable deselected", 8'h01, {7'h00, so_oe_n});
  endtask

  // busy: in progress flag set, reads ignored, done within the write time
  task automatic wait_done(input logic [7:0] fin);
    status(8'h01, 8'h01);
    cmd(CMD_READ, 16'h0000);
    m_mst.xfer(8'h00, 1'b0);
    chk("output enable while busy", 8'h01, {7'h00, so_oe_n});
    m_mst.stop();
    repeat (WC) @(posedge clk);
    status(fin, 8'hFF);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clk        = 1'b0;
    rst        = 1'b1;
    wp_n       = 1'b1;
    fails      = 0;
    n_compared = 0;
    seed       = $urandom(32'h3e61_c370);
    repeat (5) @(posedge clk);
    #5 rst = 1'b0;
    // select low since power-up: no answer until it has been high
    m_mst.xfer(CMD_RDSR, 1'b0);
    m_mst.xfer(8'h00, 1'b0);
    chk("output enable before select fall", 8'h01, {7'h00, so_oe_n});
    m_mst.stop();
    for (int md = 0; md < 2; md++) begin
      m_mst.mode3 = md[0];
      pg = 9'($urandom_range(511));
      foreach (d[i]) d[i] = 8'($urandom);
      status(8'h00, 8'hFF);
      one(CMD_WREN);
      status(8'h02, 8'hFF);
      one(CMD_WRDI);
      status(8'h00, 8'hFF);
      wq = {d[0], d[1], d[2], d[3]};
      wr(CMD_WRITE, {pg, 7'h7E}, 1'b1);
      wait_done(8'h00);
      wq = {~d[2]};
      wr(CMD_WRITE, {pg, 7'h00}, 1'b0);
      eq = {d[0], d[1]};
      rd("page tail", CMD_READ, {pg, 7'h7E}, -1);
      eq = {d[2], d[3]};
      rd("page wrap", CMD_READ, {pg, 7'h00}, 1);
      wq = {d[1]};
      wr(CMD_WRITE, 16'hFFFF, 1'b1);
      wait_done(8'h00);
      eq = {d[1]};
      rd("top byte", CMD_READ, 16'hFFFF, -1);
      sa = {5'($urandom), 2'b00, 2'($urandom), 7'($urandom)};
      wq = {d[3]};
      wr(CMD_SEC_WRITE, sa, 1'b1);
      wait_done(8'h00);
      wq = {~d[3]};
      wr(CMD_SEC_WRITE, sa | 16'h0400, 1'b1);
      wr(CMD_SEC_WRITE, sa | 16'h0200, 1'b1);
      eq = {d[3]};
      rd("sector byte", CMD_SEC_READ, (sa & 16'h007F) | 16'hF980, -1);
      eq = {};
      for (int k = 0; k < UID_BITS / 8; k++) eq.push_back(UID[UID_BITS - 1 - 8 * k -: 8]);
      rd("identifier", CMD_SEC_READ, (16'($urandom) & 16'hFDF0) | 16'h0200, -1);
      wsr(8'h80);
      wait_done(8'h80);
      @(posedge clk);
      #5 wp_n = 1'b0;
      wsr(8'h00);
      status(8'h80, 8'hFD);
      @(posedge clk);
      #5 wp_n = 1'b1;
      wsr(8'h04);
      wait_done(8'h04);
      wq = {~d[1]};
      wr(CMD_WRITE, 16'hFFFF, 1'b1);
      status(8'h06, 8'hFF);
      eq = {d[1]};
      rd("protected byte", CMD_READ, 16'hFFFF, -1);
      wsr(8'h00);
      wait_done(8'h00);
    end
    final_report();
  end
endmodule
